/* File: common/thermo_pkg.sv */
package thermo_pkg;

    // ------------------------------------------------------------
    // Word layout and codes
    // ------------------------------------------------------------
    localparam int         DATA_W     = 12;
    localparam int         CHAN_W     = 3;
    localparam int         NUM_CHAN   = 8;
    localparam logic [11:0] CODE_FULL = 12'hfff;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [2:0]  CHAN_LAST = 3'h7;
    localparam logic [2:0]  CHAN_ONE  = 3'h1;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_WORD    = 8'h08;
    localparam logic [7:0] OFF_CHAN_LO = 8'h20;
    localparam logic [7:0] OFF_CHAN_HI = 8'h3c;
    localparam int         CTRL_RAW    = 0;
    localparam int         CTRL_FAHR   = 1;
    localparam int         CTRL_RUN    = 2;
    localparam logic [2:0] CTRL_RESET  = 3'h4;

    // Stored reading of one channel
    typedef struct packed {
        logic        burnout;
        logic        negative;
        logic [11:0] value;
    } reading_t;

    // Sixteen-point word seen by the controller
    typedef struct packed {
        logic        sign;
        logic [2:0]  chan;
        logic [11:0] data;
    } chan_word_t;

    // Converter result for one channel
    typedef struct packed {
        logic [2:0]  chan;
        logic        open;
        logic        negative;
        logic [11:0] temp;
        logic [11:0] raw;
    } conv_res_t;

endpackage : thermo_pkg

/* File: hw/thermo_channel_word.sv */
`timescale 1ns/1ps
module thermo_channel_word
    import thermo_pkg::*;
#(
    parameter int NCH = NUM_CHAN
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        scan_strobe,
    input  wire logic        conv_valid,
    input  wire conv_res_t   conv_res,
    output logic             scale_fahrenheit,
    output logic [7:0]       upper_input_byte,
    output logic [7:0]       lower_input_byte
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reading_t   rd_q [NCH];
    chan_word_t word_q;
    logic [2:0] chan_q;
    logic [2:0] ctrl_q;
    logic [15:0] scan_cnt_q;
    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;
    logic       scan_pulse;
    reading_t   cur_rd;
    reading_t   cap_d;
    logic       pready_q;
    logic [31:0] prdata_q;
    logic       pslverr_q;
    logic       acc;
    logic       wr_done;
    logic [31:0] rd_d;
    logic       hit_d;

    // Register index of a channel readback address
    function automatic logic [2:0] chan_index(input logic [7:0] a);
        logic [7:0] off;
        off = a - OFF_CHAN_LO;
        return off[4:2];
    endfunction : chan_index

    // Widen a stored reading for readback
    function automatic logic [31:0] pack_rd(input reading_t r);
        return {18'h00000, r};
    endfunction : pack_rd

    // ------------------------------------------------------------
    // Scan strobe synchroniser
    // ------------------------------------------------------------
    // Strobe comes from the controller's side, so two flops first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= scan_strobe;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // One pulse per controller scan; halted while run bit is clear
    assign scan_pulse = sync2_q & ~sync3_q & ctrl_q[CTRL_RUN];

    // ------------------------------------------------------------
    // Conversion capture
    // ------------------------------------------------------------
    // Selected reading for a finished conversion
    always_comb
    begin
        cap_d.burnout  = conv_res.open;
        if (conv_res.open)
        begin
            cap_d.value    = CODE_FULL;
            cap_d.negative = 1'b0;
        end
        else if (ctrl_q[CTRL_RAW])
        begin
            // Straight binary count, linear over the input span
            cap_d.value    = conv_res.raw;
            cap_d.negative = 1'b0;
        end
        else
        begin
            cap_d.value    = conv_res.temp;
            cap_d.negative = conv_res.negative;
        end
    end

    // Converter runs at its own pace; any channel may update any time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                rd_q[i] <= '0;
            end
        end
        else if (conv_valid)
        begin
            rd_q[conv_res.chan] <= cap_d;
        end
    end

    assign cur_rd = rd_q[chan_q];

    // ------------------------------------------------------------
    // Scan hand-off
    // ------------------------------------------------------------
    // Channel pointer steps once per scan and wraps after eight
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_q <= '0;
        end
        else if (scan_pulse)
        begin
            chan_q <= chan_q + CHAN_ONE;
        end
    end

    // Word only changes at a scan, so both bytes stay coherent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_q <= '0;
        end
        else if (scan_pulse)
        begin
            word_q.sign <= cur_rd.negative;
            word_q.chan <= chan_q;
            word_q.data <= cur_rd.value;
        end
    end

    // Scan counter for software visibility
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_cnt_q <= '0;
        end
        else if (scan_pulse)
        begin
            scan_cnt_q <= scan_cnt_q + 16'h0001;
        end
    end

    // Sixteen input points, upper byte then lower byte
    assign upper_input_byte = word_q[15:8];
    assign lower_input_byte = word_q[7:0];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign acc     = psel & penable;
    assign wr_done = acc & pready_q & pwrite;

    always_comb
    begin
        rd_d  = '0;
        hit_d = 1'b1;
        if (paddr == OFF_CTRL)
        begin
            rd_d = {29'h0, ctrl_q};
        end
        else if (paddr == OFF_STATUS)
        begin
            rd_d = {13'h0, scan_cnt_q, chan_q};
        end
        else if (paddr == OFF_WORD)
        begin
            rd_d = {16'h0, word_q};
        end
        else if (paddr >= OFF_CHAN_LO && paddr <= OFF_CHAN_HI && paddr[1:0] == 2'h0)
        begin
            rd_d = pack_rd(rd_q[chan_index(paddr)]);
        end
        else
        begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit_d;
            if (acc & ~pready_q & ~pwrite)
            begin
                prdata_q <= rd_d;
            end
        end
    end

    // Control register; writes to read-only words raise no error and have no effect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (wr_done && paddr == OFF_CTRL)
        begin
            ctrl_q <= pwdata[2:0];
        end
    end

    assign pready           = pready_q;
    assign prdata           = prdata_q;
    assign pslverr          = pslverr_q;
    assign scale_fahrenheit = ctrl_q[CTRL_FAHR];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_chan_step_one: assert property (scan_pulse |=> chan_q == $past(chan_q) + CHAN_ONE)
        else $error("channel code did not step by one");

    a_chan_wrap_zero: assert property (scan_pulse && chan_q == CHAN_LAST |=> chan_q == 3'h0)
        else $error("channel code did not wrap");

    a_word_chan_code: assert property (scan_pulse |=> upper_input_byte[6:4] == $past(chan_q))
        else $error("word channel code wrong");

    a_word_data_field: assert property
        (scan_pulse |=> {upper_input_byte[3:0], lower_input_byte} == $past(cur_rd.value))
        else $error("word data field wrong");

    a_word_sign_bit: assert property (scan_pulse |=> upper_input_byte[7] == $past(cur_rd.negative))
        else $error("sign bit wrong");

    a_word_holds_stable: assert property (!scan_pulse |=> $stable(word_q))
        else $error("word changed between scans");

    a_burnout_full_code: assert property
        (conv_valid && conv_res.open && conv_res.chan == 3'h0 |=> rd_q[0].value == CODE_FULL)
        else $error("open input not reported as full code");

    a_raw_count_pass: assert property
        (conv_valid && !conv_res.open && ctrl_q[CTRL_RAW] && conv_res.chan == 3'h0
         |=> rd_q[0].value == $past(conv_res.raw) && !rd_q[0].negative)
        else $error("raw count not passed through");

    a_apb_one_wait: assert property (acc && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb ready timing wrong");

    a_scan_single_pulse: assert property (scan_pulse |=> !scan_pulse)
        else $error("more than one hand-off for one scan");

    a_burnout_flagged: assert property
        (conv_valid && conv_res.open && conv_res.chan == 3'h0 |=> rd_q[0].burnout && !rd_q[0].negative)
        else $error("open input not flagged or shown negative");

    a_store_untouched: assert property (!conv_valid |=> $stable(rd_q[0]))
        else $error("stored reading changed without a conversion");

    a_apb_error_flag: assert property (acc && !pready_q && !hit_d |=> pready_q && pslverr_q)
        else $error("unmapped access without error response");

    a_ptr_frozen_halt: assert property (!ctrl_q[CTRL_RUN] |=> $stable(chan_q))
        else $error("channel pointer moved while halted");

    c_full_sweep: cover property (scan_pulse && chan_q == CHAN_LAST);
    c_burnout_seen: cover property (conv_valid && conv_res.open);
    c_negative_word: cover property (scan_pulse && cur_rd.negative);
    c_apb_error: cover property (pready_q && pslverr_q);
    c_raw_capture: cover property (conv_valid && ctrl_q[CTRL_RAW]);

endmodule : thermo_channel_word

/* File: test/scan_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Controller side: scan strobe, byte reads
// ----------------------------------------
module scan_host
    import thermo_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       scan_req,
    input  wire logic [7:0] upper_input_byte,
    input  wire logic [7:0] lower_input_byte,
    output logic            scan_strobe,
    output chan_word_t      word_q,
    output logic            done_q
);
    logic [3:0] step_q;

    // Strobe high three cycles, then low long enough for the synchroniser
    assign scan_strobe = (step_q != 4'h0) && (step_q < 4'h4);

    // Bytes are taken late in the scan so the word has surely settled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_q <= 4'h0;
            done_q <= 1'b0;
            word_q <= '0;
        end
        else
        begin
            done_q <= (step_q == 4'h9);
            if (step_q == 4'h9)
                word_q <= {upper_input_byte, lower_input_byte};
            if (step_q != 4'h0 || scan_req)
                step_q <= (step_q == 4'h9) ? 4'h0 : step_q + 4'h1;
        end
    end
endmodule : scan_host

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench
    import thermo_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic        scan_strobe, conv_valid, scale_fahrenheit, scan_req, done_q, raw_m;
    logic [7:0]  paddr, upper_input_byte, lower_input_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] exp_v [8];
    logic [2:0]  ptr;
    conv_res_t   conv_res;
    chan_word_t  word_q, last;
    int          mismatches, comparisons;

    // ----------------------------------------
    // Clock, design and controller model
    // ----------------------------------------
    always #20 pclk = ~pclk;

    thermo_channel_word #(.NCH(8)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .scan_strobe, .conv_valid,
        .conv_res, .scale_fahrenheit, .upper_input_byte, .lower_input_byte);

    scan_host i_host (.pclk, .presetn, .scan_req, .upper_input_byte,
        .lower_input_byte, .scan_strobe, .word_q, .done_q);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic hang;
        mismatches++;
        wrap_up();
    endtask : hang

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
            hang();
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Expected stored reading follows the selection in force at capture
    task automatic conv(input logic [2:0] c, input logic o, input logic ng,
                        input logic [11:0] t, input logic [11:0] r);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_res <= {c, o, ng, t, r};
        @(posedge pclk);
        conv_valid <= 1'b0;
        exp_v[c] = o ? 13'h0fff : (raw_m ? {1'b0, r} : {ng, t});
    endtask : conv

    task automatic sweep(input int k);
        int n;
        repeat (k)
        begin
            @(posedge pclk);
            scan_req <= 1'b1;
            @(posedge pclk);
            scan_req <= 1'b0;
            for (n = 0; n < 30 && done_q !== 1'b1; n++)
                @(posedge pclk);
            if (done_q !== 1'b1)
                hang();
            last = {exp_v[ptr][12], ptr, exp_v[ptr][11:0]};
            chk("scan word", {16'h0, last}, {16'h0, word_q});
            ptr++;
        end
    endtask : sweep

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl reset", {29'h0, CTRL_RESET}, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, perr});
        apb(1'b1, OFF_WORD, 32'hffff_ffff);
        chk("read-only err", 32'h0, {31'h0, perr});
    endtask : t_regs

    // Distinct readings per channel, then a full sweep plus the wrap
    task automatic t_sweep;
        for (int i = 0; i < 8; i++)
            conv(3'(i), 1'b0, i[0], 12'(i * 12'h1f3), 12'hfff);
        sweep(9);
    endtask : t_sweep

    task automatic t_burnout;
        conv(3'h2, 1'b1, 1'b1, 12'h123, 12'h000);
        apb(1'b0, OFF_CHAN_LO + 8'h08, 32'h0);
        chk("burnout reading", 32'h2fff, rd);
        conv(3'h0, 1'b1, 1'b1, 12'h000, 12'h456);
        sweep(8);
        apb(1'b0, OFF_WORD, 32'h0);
        chk("word register", {16'h0, last}, rd);
    endtask : t_burnout

    // Raw counts at both ends of the span, then back to degrees
    task automatic t_raw;
        apb(1'b1, OFF_CTRL, 32'h5);
        raw_m = 1'b1;
        conv(3'h0, 1'b0, 1'b1, 12'h555, 12'h000);
        conv(3'h7, 1'b0, 1'b1, 12'h555, 12'hfff);
        chk("scale select", 32'h0, {31'h0, scale_fahrenheit});
        apb(1'b1, OFF_CTRL, 32'h6);
        raw_m = 1'b0;
        // Control write lands at the ready edge; look one cycle later
        @(posedge pclk);
        chk("scale select", 32'h1, {31'h0, scale_fahrenheit});
        conv(3'h3, 1'b0, 1'b1, 12'h0a5, 12'h777);
        sweep(8);
    endtask : t_raw

    initial
    begin
        mismatches = 0;
        comparisons = 0;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_valid = 1'b0;
        conv_res = '0;
        scan_req = 1'b0;
        raw_m = 1'b0;
        ptr = 3'h0;
        foreach (exp_v[i])
            exp_v[i] = 13'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sweep();
        t_burnout();
        t_raw();
        wrap_up();
    end
endmodule : testbench
